//--- dac_map.vh
// Register offsets, field positions, reset values and timing counts
// for the area-2 DRAM controller. Definitions only.
`ifndef DAC_MAP_VH
`define DAC_MAP_VH
`define DAC_OFS_BUS_WIDTH 8'h00
`define DAC_OFS_ACCESS_STATES 8'h04
`define DAC_OFS_WAIT_HIGH 8'h08
`define DAC_OFS_WAIT_LOW 8'h0c
`define DAC_OFS_BUS_CTRL_HIGH 8'h10
`define DAC_OFS_BUS_CTRL_LOW 8'h14
`define DAC_OFS_MEM_CTRL 8'h18
`define DAC_OFS_DRAM_CTRL 8'h1c
`define DAC_OFS_REFRESH_CONST 8'h20
`define DAC_OFS_REFRESH_COUNT 8'h24
`define DAC_RST_BUS_WIDTH 8'hfb
`define DAC_RST_ACCESS_STATES 8'hff
`define DAC_RST_WAIT_HIGH 8'hff
`define DAC_RST_WAIT_LOW 8'h10
`define DAC_RST_BUS_CTRL_HIGH 8'h01
`define DAC_RST_BUS_CTRL_LOW 8'h04
`define DAC_RST_MEM_CTRL 8'h44
`define DAC_RST_DRAM_CTRL 8'h81
`define DAC_RST_REFRESH_CONST 8'h4f
`define DAC_BIT_AREA2_WIDTH 2
`define DAC_BIT_W20 4
`define DAC_BIT_W21 5
`define DAC_BIT_LOWER_BYTE_COL_STROBE_SEL 4
`define DAC_BIT_AREA_SIZE 2
`define DAC_BIT_BURST 6
`define DAC_BIT_RFSH_EN 7
`define DAC_BIT_RFSH_WAIT 6
`define DAC_BIT_MATCH_FLAG 4
`define DAC_BIT_MATCH_IE 3
`define DAC_DRAM_SPACE_AREA2 3'h1
`define DAC_DRAM_BASE 24'h400000
`define DAC_DRAM_LAST 24'h4fffff
`define DAC_COL_SHIFT 9
`define DAC_SYS_PERIOD_NS 8
`endif

//--- dac_ctrl.v
// Area-2 DRAM controller: AHB-Lite register slave, memory request port,
// multiplexed RAS/CAS sequencer, CAS-before-RAS refresh timer.
// Assumes one AHB master, a synchronous memory requester, x8 DRAM pair.
//
// Notes on behaviour
// - Area 2 width bit clear: 16-bit space
// - Wait field 01 adds one wait state
// - Space select 001 makes area 2 DRAM
// - Lower strobe pin select routes lower CAS
// - Area size bit: eight 2-Mbyte areas
// - Addresses 40_0000 to 4F_FFFF hit DRAM
// - Two column strobes, one shared write
// - Refresh uses CAS before RAS
// - Refresh wait bit 0: no wait
// - Refresh counter counts clock divided by two
// - Constant 4F; match requests refresh
`timescale 1ns/1ps
`default_nettype none
`include "dac_map.vh"
module dac_ctrl #(
	parameter AW = 24
) (
	input wire clk, // System clock
	input wire rst_b, // Async reset, active low
	input wire hsel, // AHB select
	input wire [31:0] haddr, // AHB address
	input wire [1:0] htrans, // AHB transfer type
	input wire hwrite, // AHB write
	input wire [2:0] hsize, // AHB size
	input wire [31:0] hwdata, // AHB write data
	input wire hready, // AHB bus ready
	output reg [31:0] hrdata, // AHB read data
	output reg hreadyout, // AHB slave ready
	output reg hresp, // AHB response, always OKAY
	input wire mem_req, // Memory request, level until ack
	input wire [AW-1:0] mem_addr, // Byte address
	input wire mem_write, // Write request
	input wire [1:0] mem_be, // Byte enables, bit1 upper lane
	input wire [15:0] mem_wdata, // Write data
	output reg mem_ack, // Access done pulse
	output reg [15:0] mem_rdata, // Read data at ack
	output reg mem_miss, // Pulse: address not DRAM
	output reg [9:0] dram_addr, // Multiplexed address
	output reg ras_n, // Row strobe
	output reg ucas_n, // Upper-byte column strobe
	output reg lower_byte_col_strobe_n, // Dedicated lower CAS pin
	output reg lower_write_strobe_n, // Lower write pin (or lower CAS)
	output reg we_n, // Shared write strobe
	output reg oe_n, // Output enable
	input wire [15:0] dram_dq_in, // Data pins in
	output reg [15:0] dram_dq_out, // Data pins out
	output reg dram_dq_oe, // Data output enable
	output reg refresh_irq // Compare-match interrupt
);

localparam S_IDLE = 8'h01;
localparam S_PRE = 8'h02;
localparam S_ROW = 8'h04;
localparam S_COL = 8'h08;
localparam S_WAIT = 8'h10;
localparam S_DONE = 8'h20;
localparam S_RCAS = 8'h40;
localparam S_RRAS = 8'h80;

////////////////////////////////////////////////////////////////////////
// Registers

reg [7:0] area_bus_width;
reg [7:0] area_access_states;
reg [7:0] wait_states_high;
reg [7:0] wait_states_low;
reg [7:0] bus_control_high;
reg [7:0] bus_control_low;
reg [7:0] memory_control;
reg [7:0] dram_control;
reg [7:0] refresh_constant;
reg [7:0] refresh_count;
reg ph_wr;
reg [7:0] ph_addr;
reg match;

function [7:0] rd_mux;
	input [7:0] a;
	begin
		case (a)
			`DAC_OFS_BUS_WIDTH: rd_mux = area_bus_width;
			`DAC_OFS_ACCESS_STATES: rd_mux = area_access_states;
			`DAC_OFS_WAIT_HIGH: rd_mux = wait_states_high;
			`DAC_OFS_WAIT_LOW: rd_mux = wait_states_low;
			`DAC_OFS_BUS_CTRL_HIGH: rd_mux = bus_control_high;
			`DAC_OFS_BUS_CTRL_LOW: rd_mux = bus_control_low;
			`DAC_OFS_MEM_CTRL: rd_mux = memory_control;
			`DAC_OFS_DRAM_CTRL: rd_mux = dram_control;
			`DAC_OFS_REFRESH_CONST: rd_mux = refresh_constant;
			`DAC_OFS_REFRESH_COUNT: rd_mux = refresh_count;
			default: rd_mux = 8'h00;
		endcase
	end
endfunction

wire ahb_go = hsel & hready & htrans[1];
wire [7:0] wd = hwdata[7:0];

// Zero-wait slave; writes land on the edge that ends the data phase
always @(posedge clk or negedge rst_b)
begin
	if (!rst_b)
	begin
		hrdata <= 32'h00000000;
		hreadyout <= 1'b1;
		hresp <= 1'b0;
		ph_wr <= 1'b0;
		ph_addr <= 8'h00;
		area_bus_width <= `DAC_RST_BUS_WIDTH;
		area_access_states <= `DAC_RST_ACCESS_STATES;
		wait_states_high <= `DAC_RST_WAIT_HIGH;
		wait_states_low <= `DAC_RST_WAIT_LOW;
		bus_control_high <= `DAC_RST_BUS_CTRL_HIGH;
		bus_control_low <= `DAC_RST_BUS_CTRL_LOW;
		memory_control <= `DAC_RST_MEM_CTRL;
		dram_control <= `DAC_RST_DRAM_CTRL;
		refresh_constant <= `DAC_RST_REFRESH_CONST;
	end
	else
	begin
		ph_wr <= ahb_go & hwrite;
		if (ahb_go)
			ph_addr <= haddr[7:0];
		if (ahb_go && !hwrite)
			hrdata <= {24'h000000, rd_mux(haddr[7:0])};
		if (ph_wr)
		begin
			case (ph_addr)
				`DAC_OFS_BUS_WIDTH: area_bus_width <= wd;
				`DAC_OFS_ACCESS_STATES: area_access_states <= wd;
				`DAC_OFS_WAIT_HIGH: wait_states_high <= wd;
				`DAC_OFS_WAIT_LOW: wait_states_low <= wd;
				`DAC_OFS_BUS_CTRL_HIGH: bus_control_high <= wd;
				`DAC_OFS_BUS_CTRL_LOW: bus_control_low <= wd;
				`DAC_OFS_MEM_CTRL: memory_control <= wd;
				`DAC_OFS_REFRESH_CONST: refresh_constant <= wd;
				default: ;
			endcase
		end
		// Flag is cleared by writing 0; a new match wins over the clear
		if (ph_wr && ph_addr == `DAC_OFS_DRAM_CTRL)
			dram_control <= {wd[7:5],
				match | (dram_control[`DAC_BIT_MATCH_FLAG] &
				wd[`DAC_BIT_MATCH_FLAG]), wd[3:0]};
		else if (match)
			dram_control[`DAC_BIT_MATCH_FLAG] <= 1'b1;
	end
end

////////////////////////////////////////////////////////////////////////
// Refresh timer

wire [2:0] clk_sel = dram_control[2:0];
wire rf_en = dram_control[`DAC_BIT_RFSH_EN];
reg [6:0] prescale;
reg rf_pend;
reg tick;

// Prescaler: select n gives clock/2^(2n-1) for n of 1 to 4; only 001 (clock/2) is the
// configured rate, other values are a plain extension
always @*
begin
	case (clk_sel)
		3'h1: tick = prescale[0];
		3'h2: tick = &prescale[2:0];
		3'h3: tick = &prescale[4:0];
		3'h4: tick = &prescale[6:0];
		default: tick = 1'b0;
	endcase
end

always @(posedge clk or negedge rst_b)
begin
	if (!rst_b)
	begin
		prescale <= 7'h00;
		refresh_count <= 8'h00;
		match <= 1'b0;
	end
	else
	begin
		prescale <= prescale + 7'h01;
		match <= 1'b0;
		if (tick)
		begin
			if (refresh_count == refresh_constant)
			begin
				refresh_count <= 8'h00;
				match <= 1'b1;
			end
			else
				refresh_count <= refresh_count + 8'h01;
		end
	end
end

////////////////////////////////////////////////////////////////////////
// Address decode

// 2-Mbyte areas when the area size bit is set; area 2 is DRAM only when space select says so
wire [2:0] area = bus_control_low[`DAC_BIT_AREA_SIZE] ?
	mem_addr[23:21] : {2'b00, mem_addr[17]};
wire is_dram = area == 3'h2 &&
	bus_control_high[2:0] == `DAC_DRAM_SPACE_AREA2 &&
	mem_addr >= `DAC_DRAM_BASE && mem_addr <= `DAC_DRAM_LAST;
wire wide = !area_bus_width[`DAC_BIT_AREA2_WIDTH];
wire [1:0] waits = {wait_states_low[`DAC_BIT_W21],
	wait_states_low[`DAC_BIT_W20]};
wire lower_byte_col_strobe_on_lwr = bus_control_low[`DAC_BIT_LOWER_BYTE_COL_STROBE_SEL];
wire page_mode = memory_control[`DAC_BIT_BURST];
wire rf_wait = dram_control[`DAC_BIT_RFSH_WAIT];

////////////////////////////////////////////////////////////////////////
// Sequencer

reg [7:0] state;
reg [1:0] wcnt;
reg [1:0] lanes;
reg wr;
reg [14:0] open_row;
reg row_open;
wire [14:0] req_row = mem_addr[23:9];
// Narrow space: odd byte on upper lane only
wire [1:0] req_lanes = wide ? mem_be : (mem_addr[0] ? 2'b10 : 2'b01);

function [1:0] cas_pins;
	input [1:0] l;
	input on;
	begin
		cas_pins = on ? ~l : 2'b11;
	end
endfunction

always @(posedge clk or negedge rst_b)
begin
	if (!rst_b)
	begin
		state <= S_IDLE;
		wcnt <= 2'h0;
		lanes <= 2'b00;
		wr <= 1'b0;
		open_row <= 15'h0000;
		row_open <= 1'b0;
		rf_pend <= 1'b0;
		dram_addr <= 10'h000;
		ras_n <= 1'b1;
		ucas_n <= 1'b1;
		lower_byte_col_strobe_n <= 1'b1;
		lower_write_strobe_n <= 1'b1;
		we_n <= 1'b1;
		oe_n <= 1'b1;
		dram_dq_out <= 16'h0000;
		dram_dq_oe <= 1'b0;
		mem_ack <= 1'b0;
		mem_miss <= 1'b0;
		mem_rdata <= 16'h0000;
		refresh_irq <= 1'b0;
	end
	else
	begin
		mem_ack <= 1'b0;
		mem_miss <= 1'b0;
		refresh_irq <= dram_control[`DAC_BIT_MATCH_FLAG] &
			dram_control[`DAC_BIT_MATCH_IE];
		if (match && rf_en)
			rf_pend <= 1'b1;
		case (state)
			S_IDLE:
			begin
				ucas_n <= 1'b1;
				lower_byte_col_strobe_n <= 1'b1;
				lower_write_strobe_n <= 1'b1;
				we_n <= 1'b1;
				oe_n <= 1'b1;
				dram_dq_oe <= 1'b0;
				if (rf_pend)
				begin
					ras_n <= 1'b1;
					row_open <= 1'b0;
					state <= S_RCAS;
				end
				else if (mem_req && !mem_ack && !is_dram)
				begin
					mem_miss <= 1'b1;
					mem_ack <= 1'b1;
				end
				else if (mem_req && !mem_ack)
				begin
					lanes <= req_lanes;
					wr <= mem_write;
					dram_dq_out <= mem_wdata;
					if (row_open && page_mode && req_row == open_row)
					begin
						// Fast page hit: column only
						dram_addr <= {1'b0, mem_addr[9:1]};
						state <= S_COL;
					end
					else
					begin
						ras_n <= 1'b1;
						state <= S_PRE;
					end
				end
				else if (row_open && !page_mode)
				begin
					ras_n <= 1'b1;
					row_open <= 1'b0;
				end
			end
			S_PRE:
			begin
				dram_addr <= mem_addr[19:10];
				state <= S_ROW;
			end
			S_ROW:
			begin
				ras_n <= 1'b0;
				open_row <= req_row;
				row_open <= 1'b1;
				state <= S_COL;
			end
			S_COL:
			begin
				// Column is address bits 9:1, the address shifted by one
				dram_addr <= {1'b0, mem_addr[9:1]};
				we_n <= ~wr;
				oe_n <= wr;
				dram_dq_oe <= wr;
				wcnt <= waits;
				state <= S_WAIT;
			end
			S_WAIT:
			begin
				// One CAS per lane, lower CAS routed
				{ucas_n, lower_byte_col_strobe_n} <=
					{cas_pins(lanes, 1'b1) | {1'b0, lower_byte_col_strobe_on_lwr}};
				lower_write_strobe_n <= lower_byte_col_strobe_on_lwr ? ~lanes[0] : 1'b1;
				if (wcnt != 2'h0)
					wcnt <= wcnt - 2'h1;
				else
					state <= S_DONE;
			end
			S_DONE:
			begin
				mem_rdata <= dram_dq_in;
				mem_ack <= 1'b1;
				if (!page_mode)
				begin
					ras_n <= 1'b1;
					row_open <= 1'b0;
				end
				state <= S_IDLE;
			end
			S_RCAS:
			begin
				// Both CAS low before RAS
				ucas_n <= 1'b0;
				lower_byte_col_strobe_n <= lower_byte_col_strobe_on_lwr;
				lower_write_strobe_n <= ~lower_byte_col_strobe_on_lwr;
				rf_pend <= match & rf_en;
				wcnt <= rf_wait ? 2'h1 : 2'h0;
				state <= S_RRAS;
			end
			S_RRAS:
			begin
				ras_n <= 1'b0;
				if (wcnt != 2'h0)
					wcnt <= wcnt - 2'h1;
				else if (!ras_n)
				begin
					ras_n <= 1'b1;
					state <= S_IDLE;
				end
			end
			default: state <= S_IDLE;
		endcase
	end
end

endmodule
`default_nettype wire

//--- dac_ctrl_asserts.sv
// Checker on the controller's bus, request and DRAM strobe ports.
// Assumes the reset wait and refresh settings stay in force.
`timescale 1ns/1ps
`default_nettype none
module dac_ctrl_chk #(
	parameter AW = 24
) (
	input wire logic clk, // Clock
	input wire logic rst_b, // Reset
	input wire logic hreadyout, // Ready
	input wire logic hresp, // Response
	input wire logic [AW-1:0] mem_addr, // Address
	input wire logic mem_ack, // Done
	input wire logic mem_miss, // Not DRAM
	input wire logic [9:0] dram_addr, // Mux address
	input wire logic ras_n, // Row strobe
	input wire logic ucas_n, // Upper CAS
	input wire logic lower_byte_col_strobe_n, // Lower CAS
	input wire logic we_n, // Write strobe
	input wire logic oe_n, // Output enable
	input wire logic dram_dq_oe // Data drive enable
);
	wire logic cas_n = ucas_n & lower_byte_col_strobe_n;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	////////////////////////////////
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("slave not ready or not okay");
	a_ack_pulse: assert property (mem_ack |=> !mem_ack)
		else $error("ack held too long");
	a_area_decode: assert property (
		mem_ack |-> mem_miss == (mem_addr[23:20] != 4'h4))
		else $error("area decode wrong");
	// Refresh is left out: it has its own lead-in
	a_precharge_gap: assert property (
		$fell(ras_n) && cas_n |-> $past(ras_n, 2))
		else $error("row opened without precharge");
	a_row_addr: assert property (
		$fell(ras_n) && cas_n |-> dram_addr == mem_addr[19:10])
		else $error("row address wrong");
	a_col_addr: assert property (
		!ras_n && $fell(cas_n) |-> dram_addr == {1'b0, mem_addr[9:1]})
		else $error("column address wrong");
	// CAS spans two column states plus the one wait state
	a_cas_wait: assert property (
		!ras_n && $fell(cas_n) |-> !cas_n[*3] ##1 cas_n)
		else $error("column strobe width wrong");
	a_cbr_order: assert property (
		ras_n && $fell(cas_n) |-> ##[1:2] $fell(ras_n))
		else $error("refresh row strobe late");
	a_write_drive: assert property (
		!we_n |-> dram_dq_oe && oe_n)
		else $error("write strobe without driven data");
	a_read_float: assert property (
		!oe_n |-> !dram_dq_oe && we_n)
		else $error("data driven during read");
	c_hit: cover property (mem_ack && !mem_miss);
	c_miss: cover property (mem_ack && mem_miss);
	c_cbr: cover property (ras_n && $fell(cas_n));
endmodule
bind dac_ctrl dac_ctrl_chk #(.AW(AW)) u_chk (
	.clk(clk), .rst_b(rst_b), .hreadyout(hreadyout), .hresp(hresp),
	.mem_addr(mem_addr), .mem_ack(mem_ack), .mem_miss(mem_miss),
	.dram_addr(dram_addr), .ras_n(ras_n), .ucas_n(ucas_n),
	.lower_byte_col_strobe_n(lower_byte_col_strobe_n), .we_n(we_n),
	.oe_n(oe_n), .dram_dq_oe(dram_dq_oe)
);
`default_nettype wire

//--- dac_dram_model.sv
// Behavioural pair of x8 DRAMs: shared row strobe, one CAS per lane.
// Assumes early write: write strobe is low before CAS falls.
`timescale 1ns/1ps
`default_nettype none
module dac_dram_model (
	input wire logic ras_n, // Row strobe
	input wire logic up_cas_n, // Upper lane CAS
	input wire logic lo_cas_n, // Lower lane CAS
	input wire logic we_n, // Shared write
	input wire logic [9:0] addr, // Mux address
	input wire logic [15:0] din, // Write data
	output logic [15:0] dout, // Read data
	output int n_ref // Refreshes seen
);
	bit [15:0] mem [int];
	logic [9:0] row;
	int k;
	initial n_ref = 0;
	initial dout = 16'h0;
	////////////////////////////////
	always @(negedge ras_n)
		if (!up_cas_n || !lo_cas_n)
			n_ref++;
		else
			row = addr;
	always @(negedge up_cas_n or negedge lo_cas_n)
	begin
		k = {row, addr};
		if (!ras_n && !we_n && !up_cas_n)
			mem[k][15:8] = din[15:8];
		if (!ras_n && !we_n && !lo_cas_n)
			mem[k][7:0] = din[7:0];
		if (!ras_n)
			dout = mem.exists(k) ? mem[k] : 16'h0;
	end
	// Released lines show the inverse, so stale data never matches
	always @(posedge up_cas_n or posedge lo_cas_n)
		if (up_cas_n && lo_cas_n)
			dout = ~dout;
endmodule
`default_nettype wire

//--- dac_tb.sv
// Bench: register and DRAM traffic through the controller ports.
// Assumes the DRAM model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`include "dac_map.vh"
module tb;
	logic clk = 0, rst_b = 0, hsel = 0, hwrite = 0, mem_req = 0;
	logic mem_write = 0, lsel = 0;
	logic [1:0] htrans = '0, mem_be = '0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
	logic [23:0] mem_addr = '0;
	logic [15:0] mem_wdata = '0, mem_rdata, dq_in, dq_out, w;
	logic [9:0] dram_addr;
	logic hreadyout, hresp, mem_ack, mem_miss, ras_n, ucas_n, lc_n, lw_n;
	logic we_n, refresh_irq, m;
	int fails = 0, n_compared = 0, n_ref, n_lc = 0, n_lw = 0, t, tm, r = 0;
	logic [7:0] rv [9] = '{8'hfb, 8'hff, 8'hff, 8'h10, 8'h01, 8'h04,
		8'h44, 8'h81, 8'h4f};
	logic [23:0] ma [4] = '{24'h3ffffe, 24'h400000, 24'h4ffffe, 24'h500000};
	dac_ctrl u_dut (
		.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .mem_req(mem_req), .mem_addr(mem_addr),
		.mem_write(mem_write), .mem_be(mem_be), .mem_wdata(mem_wdata),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_miss(mem_miss),
		.dram_addr(dram_addr), .ras_n(ras_n), .ucas_n(ucas_n),
		.lower_byte_col_strobe_n(lc_n), .lower_write_strobe_n(lw_n),
		.we_n(we_n), .oe_n(), .dram_dq_in(dq_in), .dram_dq_out(dq_out),
		.dram_dq_oe(), .refresh_irq(refresh_irq)
	);
	dac_dram_model u_mem (
		.ras_n(ras_n), .up_cas_n(ucas_n), .lo_cas_n(lsel ? lw_n : lc_n),
		.we_n(we_n), .addr(dram_addr), .din(dq_out), .dout(dq_in),
		.n_ref(n_ref)
	);
	initial forever #4 clk = ~clk;
	always @(negedge lc_n) n_lc++;
	always @(negedge lw_n) n_lw++;
	////////////////////////////////
	task check(input string nm, input logic [31:0] got, exp);
		n_compared++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task print_verdict(input bit tmo);
		fails += tmo;
		$display("compared %0d mismatched %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task rdy;
		do
		begin
			@(posedge clk);
			if (r++ > 50)
				print_verdict(1);
		end
		while (hreadyout !== 1'b1);
		r = 0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		haddr <= {24'h0, a};
		hwrite <= 1'b1;
		htrans <= 2'h2;
		rdy;
		htrans <= 2'h0;
		hwdata <= d;
		rdy;
	endtask
	task rdr(input logic [7:0] a);
		haddr <= {24'h0, a};
		hwrite <= 1'b0;
		htrans <= 2'h2;
		rdy;
		htrans <= 2'h0;
		rdy;
		rd = hrdata;
	endtask
	task acc(input logic [23:0] a, input logic wen, input logic [1:0] ln,
		input logic [15:0] d);
		mem_addr <= a;
		mem_write <= wen;
		mem_be <= ln;
		mem_wdata <= d;
		mem_req <= 1'b1;
		t = 0;
		do
		begin
			@(posedge clk);
			if (t++ > 60)
				print_verdict(1);
		end
		while (mem_ack !== 1'b1);
		w = mem_rdata;
		m = mem_miss;
		mem_req <= 1'b0;
		@(posedge clk);
	endtask
	// Leaves t at the cycles waited from the call to the next refresh
	task sync;
		r = n_ref;
		t = 0;
		while (n_ref == r)
		begin
			@(posedge clk);
			if (t++ > 1000)
				print_verdict(1);
		end
		r = 0;
	endtask
	////////////////////////////////
	initial
	begin
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		hsel <= 1'b1;
		@(posedge clk);
		foreach (rv[i])
		begin
			rdr(8'(i * 4));
			check("reset", rd, rv[i]);
		end
		wr(8'h28, 32'h5a);
		rdr(8'h28);
		check("unmapped", rd, 32'h0);
		wr(8'h04, 32'h5a);
		rdr(8'h04);
		check("access states", rd, 32'h5a);
		$display("test registers done");
		// Refresh just ran, so the page is closed and none is due
		sync;
		tick(4);
		acc(24'h400010, 1'b1, 2'h3, 16'ha5c3);
		tm = t;
		acc(24'h400012, 1'b1, 2'h3, 16'h1234);
		check("page gain", tm - t, 2);
		acc(24'h400010, 1'b1, 2'h1, 16'hff00);
		acc(24'h400010, 1'b0, 2'h3, 16'h0);
		check("lane", w, 16'ha500);
		acc(24'h400012, 1'b0, 2'h3, 16'h0);
		check("column", w, 16'h1234);
		acc(24'h400410, 1'b0, 2'h3, 16'h0);
		check("row", w, 16'h0);
		foreach (ma[i])
		begin
			acc(ma[i], 1'b0, 2'h3, 16'h0);
			check("miss", m, ma[i][23:20] != 4'h4);
		end
		$display("test dram done");
		sync;
		tick(4);
		n_lc = 0;
		acc(24'h400020, 1'b1, 2'h1, 16'h0077);
		check("lower pin", n_lc, 1);
		wr(`DAC_OFS_BUS_CTRL_LOW, 32'h14);
		lsel = 1'b1;
		n_lc = 0;
		n_lw = 0;
		acc(24'h400020, 1'b0, 2'h3, 16'h0);
		check("write pin", {n_lc[15:0], n_lw[15:0]}, 32'h1);
		check("routed", w[7:0], 8'h77);
		$display("test strobes done");
		sync;
		sync;
		check("interval", t, 160);
		wr(`DAC_OFS_REFRESH_CONST, 32'h09);
		sync;
		sync;
		check("short interval", t, 20);
		wr(`DAC_OFS_REFRESH_CONST, 32'h4f);
		sync;
		rdr(`DAC_OFS_DRAM_CTRL);
		check("flag", rd[4], 1'b1);
		check("irq masked", refresh_irq, 1'b0);
		wr(`DAC_OFS_DRAM_CTRL, 32'h99);
		tick(3);
		check("irq on", refresh_irq, 1'b1);
		wr(`DAC_OFS_DRAM_CTRL, 32'h81);
		tick(3);
		check("irq off", refresh_irq, 1'b0);
		rdr(`DAC_OFS_DRAM_CTRL);
		check("flag clear", rd[4], 1'b0);
		$display("test refresh done");
		print_verdict(0);
	end
endmodule
`default_nettype wire
